//--- mazf_core.sv
// shared constants for the median / averaging / zone filter, plus its sorting array
`timescale 1ns/1ps
`default_nettype none

package mazf_pkg;
	// ****************************************************************
	// register map (byte addresses, one 32-bit word each)
	// ****************************************************************
	localparam logic [7:0] MAZF_OFS_CTRL = 8'h00;
	localparam logic [7:0] MAZF_OFS_ZONE = 8'h04;
	localparam logic [7:0] MAZF_OFS_AUX_LO = 8'h08;
	localparam logic [7:0] MAZF_OFS_AUX_HI = 8'h0C;
	localparam logic [7:0] MAZF_OFS_T1_LO = 8'h10;
	localparam logic [7:0] MAZF_OFS_T1_HI = 8'h14;
	localparam logic [7:0] MAZF_OFS_T2_LO = 8'h18;
	localparam logic [7:0] MAZF_OFS_T2_HI = 8'h1C;
	localparam logic [7:0] MAZF_OFS_STATUS = 8'h20;
	localparam logic [7:0] MAZF_OFS_RESULT = 8'h24;
	// ****************************************************************
	// field positions and reset values
	// ****************************************************************
	localparam int MAZF_CTRL_MED_LO = 0;
	localparam int MAZF_CTRL_WIN_LO = 2;
	localparam int MAZF_CTRL_RES_BIT = 4;
	localparam int MAZF_ZONE_EN_LO = 0;
	localparam int MAZF_ZONE_MODE_LO = 4;
	localparam int MAZF_STATUS_FLAG_LO = 0;
	localparam int MAZF_STATUS_BUSY_BIT = 8;
	localparam int MAZF_RESULT_CHAN_LO = 16;
	localparam logic [31:0] MAZF_RST_WORD = 32'h0000_0000;
	// ****************************************************************
	// sizes, channels and zone modes
	// ****************************************************************
	localparam int MAZF_DATA_W = 12;
	localparam int MAZF_LOW_RES_W = 10;
	localparam int MAZF_DEPTH = 16;
	localparam int MAZF_CNT_W = 5;
	localparam int MAZF_NUM_ZONE = 3;
	typedef enum logic [2:0] {
		MAZF_CH_X = 3'h0,
		MAZF_CH_Y = 3'h1,
		MAZF_CH_Z1 = 3'h2,
		MAZF_CH_Z2 = 3'h3,
		MAZF_CH_AUX = 3'h4,
		MAZF_CH_THERM1 = 3'h5,
		MAZF_CH_THERM2 = 3'h6,
		MAZF_CH_SPARE = 3'h7
	} mazf_chan_t;
	localparam logic [1:0] MAZF_ZONE_ABOVE = 2'h0;
	localparam logic [1:0] MAZF_ZONE_BETWEEN = 2'h1;
	localparam logic [1:0] MAZF_ZONE_BELOW = 2'h2;
	// plan of one collection: how many samples, which sorted slots to add, how to divide
	typedef struct packed {
		logic [4:0] n;
		logic [3:0] first;
		logic [4:0] span;
		logic dup;
		logic [3:0] mid;
		logic [2:0] shift;
	} mazf_plan_t;
endpackage

// ****************************************************************
// sorted sample array: each push inserts in ascending order
// ****************************************************************
module mazf_sort_array
	import mazf_pkg::*;
#(
	parameter int DW = MAZF_DATA_W,
	parameter int DEPTH = MAZF_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// insertion
	input wire logic push_in,
	input wire logic [MAZF_CNT_W-1:0] used_in,
	input wire logic [DW-1:0] data_in,
	// contents, ascending from slot 0
	output logic [DEPTH-1:0][DW-1:0] sorted_out
);
	logic [MAZF_CNT_W-1:0] pos;

	// insertion slot = number of stored entries not above the new value
	always_comb begin
		pos = '0;
		for (int i = 0; i < DEPTH; i++) begin
			if ((MAZF_CNT_W'(i) < used_in) && (sorted_out[i] <= data_in)) begin
				pos = pos + 1'b1;
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			sorted_out <= '0;
		end else if (push_in) begin
			for (int i = 0; i < DEPTH; i++) begin
				if (MAZF_CNT_W'(i) == pos) begin
					sorted_out[i] <= data_in; // RULE6
				end else if ((MAZF_CNT_W'(i) > pos) && (i > 0)) begin
					sorted_out[i] <= sorted_out[i-1]; // RULE6
				end
			end
		end
	end
endmodule

`default_nettype wire

//--- mazf_seq_model.sv
// converter sequencer model offering queued samples to the filter
`timescale 1ns/1ps
`default_nettype none
module mazf_seq_model
	import mazf_pkg::*;
(
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// sample stream
	input wire logic ready_in,
	output logic valid_out,
	output logic [MAZF_DATA_W-1:0] data_out,
	output logic [2:0] chan_out
);
	// {channel, value} words loaded by the bench; slow inserts random gaps
	logic [14:0] q[$];
	bit slow;
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			valid_out <= 1'h0;
			data_out <= 12'h000;
			chan_out <= 3'h0;
		end else if (valid_out && !ready_in) begin
			// an offered sample holds until it is taken
		end else if (q.size() > 0 && !(slow && $urandom_range(1, 0) == 0)) begin
			valid_out <= 1'h1;
			{chan_out, data_out} <= q.pop_front();
		end else begin
			// released lines move, so a stale value can never look valid
			valid_out <= 1'h0;
			data_out <= ~data_out;
			chan_out <= ~chan_out;
		end
	end
endmodule
`default_nettype wire

//--- mazf_top.sv
// median / averaging filter followed by the zone detector, with a wishbone register file
//
// Notes on behaviour
// RULE1 - median, averaging or combined mode by sizes
// RULE2 - median code selects 1, 3, 7, 15
// RULE3 - median 1: window code selects 1,4,8,16
// RULE4 - median above 1: window 1, 3, 7
// RULE5 - software avoids median above 1, window 11
// RULE6 - collected samples are sorted by value
// RULE7 - both sizes 1: sample passes unchanged
// RULE8 - median 1: average of W samples
// RULE9 - window 1: middle of M sorted
// RULE10 - both above 1: middle W plus median
// RULE11 - other invalid pairs act as median only
// RULE12 - filter serves every analog channel
// RULE13 - zone detector drops data outside zone
// RULE14 - zones: above high, between, below low
// RULE15 - per-channel thresholds and zone enables
// RULE16 - touch coordinates skip the zone detector
// RULE17 - zone hit: alert pin low, flag set
// RULE18 - filter first, zone detector second
// RULE19 - average by shift, fraction truncated
// RULE20 - resolution width; one output per collection
//
// The register offsets and the Wishbone interface to the registers were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module mazf_top
	import mazf_pkg::*;
#(
	parameter int DW = MAZF_DATA_W,
	parameter int DEPTH = MAZF_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// wishbone slave
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [7:0] wb_adr_in,
	input wire logic [3:0] wb_sel_in,
	input wire logic [31:0] wb_dat_in,
	output logic [31:0] wb_dat_out,
	output logic wb_ack_out,
	// conversion results from the sequencer
	input wire logic sample_valid_in,
	input wire logic [DW-1:0] sample_data_in,
	input wire logic [2:0] sample_chan_in,
	output logic sample_ready_out,
	// filtered results to the result registers
	output logic result_valid_out,
	output logic [DW-1:0] result_data_out,
	output logic [2:0] result_chan_out,
	output logic result_alert_pin_n_out
);
	typedef enum logic [1:0] {
		MAZF_ST_COLLECT,
		MAZF_ST_SUM,
		MAZF_ST_EMIT
	} mazf_state_t;

	localparam int SUM_W = DW + MAZF_CNT_W;

	// ****************************************************************
	// helper functions
	// ****************************************************************
	// merge a bus write into a register honouring byte lanes
	function automatic logic [31:0] lane_merge(input logic [31:0] old_word,
		input logic [31:0] new_word, input logic [3:0] sel);
		logic [31:0] res;
		res = old_word;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				res[b*8 +: 8] = new_word[b*8 +: 8];
			end
		end
		return res;
	endfunction

	// size decode; reserved and invalid pairs fall back to median only
	function automatic mazf_plan_t size_plan(input logic [1:0] med_sel, input logic [1:0] win_sel);
		mazf_plan_t p;
		p = '{n: 5'h01, first: 4'h0, span: 5'h01, dup: 1'b0, mid: 4'h0, shift: 3'h0}; // RULE7
		unique case (med_sel) // RULE1 RULE2
			2'h0: begin
				unique case (win_sel) // RULE3 RULE8
					2'h0: p.n = 5'h01;
					2'h1: begin
						p.n = 5'h04;
						p.span = 5'h04;
						p.shift = 3'h2;
					end
					2'h2: begin
						p.n = 5'h08;
						p.span = 5'h08;
						p.shift = 3'h3;
					end
					2'h3: begin
						p.n = 5'h10;
						p.span = 5'h10;
						p.shift = 3'h4;
					end
				endcase
			end
			2'h1: begin
				p.n = 5'h03; // RULE9 RULE11
				p.mid = 4'h1;
				p.first = 4'h1;
			end
			2'h2: begin
				p.n = 5'h07;
				p.mid = 4'h3;
				p.first = 4'h3; // RULE9 RULE11
				if (win_sel == 2'h1) begin
					p.first = 4'h2; // RULE4 RULE10
					p.span = 5'h03;
					p.dup = 1'b1;
					p.shift = 3'h2;
				end
			end
			2'h3: begin
				p.n = 5'h0F;
				p.mid = 4'h7;
				p.first = 4'h7; // RULE9 RULE11
				if (win_sel == 2'h1) begin
					p.first = 4'h6; // RULE4 RULE10
					p.span = 5'h03;
					p.dup = 1'b1;
					p.shift = 3'h2;
				end else if (win_sel == 2'h2) begin
					p.first = 4'h4; // RULE4 RULE10
					p.span = 5'h07;
					p.dup = 1'b1;
					p.shift = 3'h3;
				end
			end
		endcase
		return p;
	endfunction

	// zone test for one value against its thresholds
	function automatic logic zone_hit(input logic [1:0] mode, input logic [DW-1:0] val,
		input logic [DW-1:0] lo, input logic [DW-1:0] hi);
		logic hit;
		hit = 1'b0;
		unique case (mode) // RULE14
			MAZF_ZONE_ABOVE: hit = (val >= hi);
			MAZF_ZONE_BETWEEN: hit = (val > lo) && (val < hi);
			MAZF_ZONE_BELOW: hit = (val <= lo);
			default: hit = 1'b0;
		endcase
		return hit;
	endfunction

	// ****************************************************************
	// registers
	// ****************************************************************
	logic [31:0] ctrl;
	logic [31:0] zone_cfg;
	logic [DW-1:0] thr_lo [MAZF_NUM_ZONE];
	logic [DW-1:0] thr_hi [MAZF_NUM_ZONE];
	logic [MAZF_NUM_ZONE-1:0] result_ready_flag;
	mazf_state_t state;
	mazf_state_t next_state;
	logic [MAZF_CNT_W-1:0] count;
	logic [2:0] cur_chan;
	mazf_plan_t plan;
	logic [MAZF_CNT_W-1:0] term;
	logic [SUM_W-1:0] acc;
	logic [DEPTH-1:0][DW-1:0] sorted;
	logic wb_req;
	logic wb_wr;
	logic take;
	logic restart;
	logic [MAZF_CNT_W-1:0] used_eff;
	logic [MAZF_CNT_W-1:0] last_term;
	logic [3:0] slot;
	logic [DW-1:0] avg_val;
	logic [DW-1:0] res_mask;
	logic zone_sel;
	logic [1:0] zone_idx;
	logic zone_en;
	logic zone_ok;
	logic [MAZF_NUM_ZONE-1:0] flag_set;
	logic [MAZF_NUM_ZONE-1:0] flag_clr;

	assign wb_req = wb_cyc_in && wb_stb_in && !wb_ack_out;
	assign wb_wr = wb_req && wb_we_in;

	// ****************************************************************
	// wishbone slave: one wait state, unmapped reads as zero
	// ****************************************************************
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wb_ack_out <= 1'b0;
		end else begin
			wb_ack_out <= wb_req;
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			ctrl <= MAZF_RST_WORD;
			zone_cfg <= MAZF_RST_WORD;
		end else if (wb_wr && (wb_adr_in == MAZF_OFS_CTRL)) begin
			ctrl <= lane_merge(ctrl, wb_dat_in, wb_sel_in);
		end else if (wb_wr && (wb_adr_in == MAZF_OFS_ZONE)) begin
			zone_cfg <= lane_merge(zone_cfg, wb_dat_in, wb_sel_in); // RULE15
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			for (int z = 0; z < MAZF_NUM_ZONE; z++) begin
				thr_lo[z] <= '0;
				thr_hi[z] <= '0;
			end
		end else if (wb_wr) begin
			for (int z = 0; z < MAZF_NUM_ZONE; z++) begin
				// each monitored channel owns its own threshold pair
				if (wb_adr_in == MAZF_OFS_AUX_LO + 8'(z * 8)) begin
					thr_lo[z] <= DW'(lane_merge(32'(thr_lo[z]), wb_dat_in, wb_sel_in)); // RULE15
				end
				if (wb_adr_in == MAZF_OFS_AUX_HI + 8'(z * 8)) begin
					thr_hi[z] <= DW'(lane_merge(32'(thr_hi[z]), wb_dat_in, wb_sel_in)); // RULE15
				end
			end
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			wb_dat_out <= '0;
		end else if (wb_req) begin
			wb_dat_out <= '0;
			unique case (wb_adr_in)
				MAZF_OFS_CTRL: wb_dat_out <= ctrl;
				MAZF_OFS_ZONE: wb_dat_out <= zone_cfg;
				MAZF_OFS_AUX_LO: wb_dat_out <= 32'(thr_lo[0]);
				MAZF_OFS_AUX_HI: wb_dat_out <= 32'(thr_hi[0]);
				MAZF_OFS_T1_LO: wb_dat_out <= 32'(thr_lo[1]);
				MAZF_OFS_T1_HI: wb_dat_out <= 32'(thr_hi[1]);
				MAZF_OFS_T2_LO: wb_dat_out <= 32'(thr_lo[2]);
				MAZF_OFS_T2_HI: wb_dat_out <= 32'(thr_hi[2]);
				MAZF_OFS_STATUS: begin
					wb_dat_out[MAZF_STATUS_FLAG_LO +: MAZF_NUM_ZONE] <= result_ready_flag;
					wb_dat_out[MAZF_STATUS_BUSY_BIT] <= (state != MAZF_ST_COLLECT) || (count != '0);
				end
				MAZF_OFS_RESULT: begin
					wb_dat_out[DW-1:0] <= result_data_out;
					wb_dat_out[MAZF_RESULT_CHAN_LO +: 3] <= result_chan_out;
				end
				default: wb_dat_out <= '0;
			endcase
		end
	end

	// ****************************************************************
	// collection into the sorted array
	// ****************************************************************
	assign take = sample_valid_in && sample_ready_out;
	// a channel change mid-collection drops the partial set; mixing channels would be garbage
	assign restart = take && (count != '0) && (sample_chan_in != cur_chan);
	assign used_eff = restart ? '0 : count;
	assign res_mask = ctrl[MAZF_CTRL_RES_BIT] ? {DW{1'b1}} : DW'({MAZF_LOW_RES_W{1'b1}});

	mazf_sort_array #(
		.DW(DW),
		.DEPTH(DEPTH)
	) u_sort (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.push_in(take),
		.used_in(used_eff),
		.data_in(sample_data_in & res_mask), // RULE20
		.sorted_out(sorted)
	);

	always_comb begin
		next_state = state;
		unique case (state)
			MAZF_ST_COLLECT: begin
				if (take && (used_eff + 1'b1 == plan_now().n)) begin
					next_state = MAZF_ST_SUM; // RULE20
				end
			end
			MAZF_ST_SUM: begin
				if (term == last_term) begin
					next_state = MAZF_ST_EMIT;
				end
			end
			MAZF_ST_EMIT: next_state = MAZF_ST_COLLECT;
		endcase
	end

	// plan in force: latched at the first sample so a mid-set write cannot split a set
	function automatic mazf_plan_t plan_now();
		return (used_eff == '0) ? size_plan(ctrl[MAZF_CTRL_MED_LO +: 2], ctrl[MAZF_CTRL_WIN_LO +: 2])
			: plan;
	endfunction

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			state <= MAZF_ST_COLLECT;
			sample_ready_out <= 1'b0;
		end else begin
			state <= next_state;
			sample_ready_out <= (next_state == MAZF_ST_COLLECT);
		end
	end

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			count <= '0;
			cur_chan <= '0;
			plan <= '0;
		end else if (state == MAZF_ST_EMIT) begin
			count <= '0;
		end else if (take) begin
			count <= used_eff + 1'b1;
			cur_chan <= sample_chan_in; // RULE12
			plan <= plan_now();
		end
	end

	// ****************************************************************
	// averaging: one sorted slot added per cycle, median slot added again when plan.dup is set
	// ****************************************************************
	assign last_term = plan.span + MAZF_CNT_W'(plan.dup) - 1'b1;
	assign slot = (term < plan.span) ? 4'(plan.first + 4'(term)) : plan.mid; // RULE10

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			term <= '0;
			acc <= '0;
		end else if (state == MAZF_ST_SUM) begin
			term <= term + 1'b1;
			acc <= acc + SUM_W'(sorted[slot]); // RULE8 RULE10
		end else begin
			term <= '0;
			acc <= '0;
		end
	end

	assign avg_val = DW'(acc >> plan.shift); // RULE19

	// ****************************************************************
	// zone detector on the filtered value
	// ****************************************************************
	always_comb begin
		zone_sel = 1'b1;
		zone_idx = 2'h0;
		unique case (cur_chan) // RULE16
			MAZF_CH_AUX: zone_idx = 2'h0;
			MAZF_CH_THERM1: zone_idx = 2'h1;
			MAZF_CH_THERM2: zone_idx = 2'h2;
			default: zone_sel = 1'b0;
		endcase
	end

	assign zone_en = zone_sel && zone_cfg[MAZF_ZONE_EN_LO + 32'(zone_idx)]; // RULE15
	assign zone_ok = zone_hit(zone_cfg[MAZF_ZONE_MODE_LO + 32'(zone_idx) * 2 +: 2], avg_val,
		thr_lo[zone_idx], thr_hi[zone_idx]);

	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			result_valid_out <= 1'b0;
			result_data_out <= '0;
			result_chan_out <= '0;
		end else begin
			result_valid_out <= 1'b0;
			// a disabled zone passes everything; an enabled one keeps only hits
			if ((state == MAZF_ST_EMIT) && (!zone_en || zone_ok)) begin // RULE13 RULE18
				result_valid_out <= 1'b1;
				result_data_out <= avg_val;
				result_chan_out <= cur_chan;
			end
		end
	end

	always_comb begin
		flag_set = '0;
		if ((state == MAZF_ST_EMIT) && zone_en && zone_ok) begin
			flag_set[zone_idx] = 1'b1; // RULE17
		end
		flag_clr = '0;
		if (wb_wr && (wb_adr_in == MAZF_OFS_STATUS) && wb_sel_in[0]) begin
			flag_clr = wb_dat_in[MAZF_STATUS_FLAG_LO +: MAZF_NUM_ZONE];
		end
	end

	// set wins over a same-cycle write-one-to-clear
	always_ff @(posedge clk_in) begin
		if (rst_in) begin
			result_ready_flag <= '0;
			result_alert_pin_n_out <= 1'b1;
		end else begin
			result_ready_flag <= (result_ready_flag & ~flag_clr) | flag_set; // RULE17
			result_alert_pin_n_out <= ~|((result_ready_flag & ~flag_clr) | flag_set); // RULE17
		end
	end
endmodule

`default_nettype wire

//--- mazf_top_assertions.sv
// assertion checker on the ports of the median / averaging / zone filter
`timescale 1ns/1ps
`default_nettype none
module mazf_top_checker
	import mazf_pkg::*;
#(
	parameter int DW = MAZF_DATA_W,
	parameter int DEPTH = MAZF_DEPTH
) (
	// clock and reset
	input wire logic clk_in,
	input wire logic rst_in,
	// register bus
	input wire logic wb_cyc_in,
	input wire logic wb_stb_in,
	input wire logic wb_we_in,
	input wire logic [31:0] wb_dat_out,
	input wire logic wb_ack_out,
	// sample and result streams
	input wire logic sample_ready_out,
	input wire logic result_valid_out,
	input wire logic [DW-1:0] result_data_out,
	input wire logic [2:0] result_chan_out,
	input wire logic result_alert_pin_n_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (rst_in);
	// ****************************************************************
	// register bus
	// ****************************************************************
	property p_ack_one;
		wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out;
	endproperty
	a_ack_one: assert property (p_ack_one) else $error("no ack after request");
	property p_ack_pulse;
		wb_ack_out |=> !wb_ack_out;
	endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
	property p_dat_hold;
		$changed(wb_dat_out) |-> wb_ack_out;
	endproperty
	a_dat_hold: assert property (p_dat_hold) else $error("read data moved without ack");
	// ****************************************************************
	// filter and zone outputs
	// ****************************************************************
	property p_valid_pulse;
		result_valid_out |=> !result_valid_out;
	endproperty
	a_valid_pulse: assert property (p_valid_pulse) else $error("result valid too long");
	property p_emit_after_busy;
		result_valid_out |-> !$past(sample_ready_out);
	endproperty
	a_emit_after_busy: assert property (p_emit_after_busy) else $error("result while taking");
	// the longest sum is sixteen terms, so forty cycles leaves ample margin
	property p_ready_back;
		$fell(sample_ready_out) |-> ##[1:40] sample_ready_out;
	endproperty
	a_ready_back: assert property (p_ready_back) else $error("ready stuck low");
	property p_result_hold;
		$changed(result_data_out) || $changed(result_chan_out) |-> result_valid_out;
	endproperty
	a_result_hold: assert property (p_result_hold) else $error("result moved unkept");
	property p_alert_cause;
		$fell(result_alert_pin_n_out) |-> result_valid_out && result_chan_out inside {3'h4, 3'h5, 3'h6};
	endproperty
	a_alert_cause: assert property (p_alert_cause) else $error("alert without zone hit");
	property p_touch_no_alert;
		result_valid_out && result_chan_out < 3'h4 |-> !$fell(result_alert_pin_n_out);
	endproperty
	a_touch_no_alert: assert property (p_touch_no_alert) else $error("touch result alerted");
	property p_alert_release;
		$rose(result_alert_pin_n_out) |-> $past(wb_we_in && wb_stb_in) || $past(wb_we_in && wb_stb_in, 2);
	endproperty
	a_alert_release: assert property (p_alert_release) else $error("alert released unasked");
endmodule
bind mazf_top mazf_top_checker #(.DW(DW), .DEPTH(DEPTH)) i_mazf_top_checker (.clk_in, .rst_in,
	.wb_cyc_in, .wb_stb_in, .wb_we_in, .wb_dat_out, .wb_ack_out, .sample_ready_out,
	.result_valid_out, .result_data_out, .result_chan_out, .result_alert_pin_n_out);
`default_nettype wire

//--- tb_top.sv
// self-checking bench: filter modes, zone detection and register access
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import mazf_pkg::*;
	// ****************************************************************
	// signals
	// ****************************************************************
	logic clk_in, rst_in, cyc, stb, we, ack, s_valid, s_ready, r_valid, alert_n, hit;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat, rd;
	logic [11:0] s_data, r_data, lo, hi, v;
	logic [2:0] s_chan, r_chan, fl;
	logic [14:0] exp_q[$];
	logic [11:0] smp[$];
	int bad_count, checked, cycles, n, k;
	initial begin
		clk_in = 1'h0;
		forever #2.5 clk_in = ~clk_in;
	end
	mazf_top i_mazf_top (.clk_in(clk_in), .rst_in(rst_in), .wb_cyc_in(cyc), .wb_stb_in(stb),
		.wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wdat), .wb_dat_out(rdat),
		.wb_ack_out(ack), .sample_valid_in(s_valid), .sample_data_in(s_data),
		.sample_chan_in(s_chan), .sample_ready_out(s_ready), .result_valid_out(r_valid),
		.result_data_out(r_data), .result_chan_out(r_chan), .result_alert_pin_n_out(alert_n));
	mazf_seq_model i_mazf_seq_model (.clk_in(clk_in), .rst_in(rst_in), .ready_in(s_ready),
		.valid_out(s_valid), .data_out(s_data), .chan_out(s_chan));
	// ****************************************************************
	// tasks
	// ****************************************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] want);
		checked++;
		if (seen !== want) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, want, seen);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && checked > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_in);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		sel <= 4'hF;
		do @(posedge clk_in); while (ack !== 1'h1);
		rd = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
	endtask
	// sorted-array reference: median, plain average or middle average
	function automatic logic [11:0] expv(input int m, input int w, input logic [11:0] s[$]);
		int mm, ww, sum;
		mm = (1 << (m + 1)) - 1;
		ww = (m == 0) ? (w == 0 ? 1 : 1 << (w + 1)) : (1 << (w + 1)) - 1;
		sum = 0;
		s.sort();
		if (m > 0 && ww >= mm) ww = 1;
		if (m == 0) begin
			foreach (s[i]) sum += s[i];
			return 12'(sum / ww);
		end
		if (ww == 1) return s[mm / 2];
		for (int i = mm / 2 - ww / 2; i <= mm / 2 + ww / 2; i++) sum += s[i];
		return 12'((sum + s[mm / 2]) / (ww + 1));
	endfunction
	task automatic drain();
		int t, ok;
		t = 0;
		ok = 0;
		@(posedge clk_in);
		do begin
			@(posedge clk_in);
			t++;
			// idle must hold on two edges: the model's queue pop races with this read
			if (i_mazf_seq_model.q.size() == 0 && s_valid !== 1'h1 && s_ready === 1'h1 &&
				r_valid !== 1'h1 && exp_q.size() == 0) ok++;
			else ok = 0;
		end while (t < 300 && ok < 2);
		check("drain", 32'(t == 300), 32'h0);
	endtask
	task automatic send_set(input int m, input int w, input logic [2:0] ch, input logic keep,
		input logic [11:0] vs[$]);
		foreach (vs[i]) i_mazf_seq_model.q.push_back({ch, vs[i]});
		if (keep) exp_q.push_back({ch, expv(m, w, vs)});
		drain();
	endtask
	// ****************************************************************
	// result monitor and timeout
	// ****************************************************************
	always @(posedge clk_in) begin
		if (!rst_in && r_valid === 1'h1) begin
			if (exp_q.size() == 0) check("unexpected result", 32'h1, 32'h0);
			else check("result", 32'({r_chan, r_data}), 32'(exp_q.pop_front()));
		end
	end
	always @(posedge clk_in) begin
		cycles++;
		if (cycles == 60000) begin
			bad_count++;
			finish_test();
		end
	end
	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		rst_in = 1'h1;
		{cyc, stb, we, adr, sel, wdat} = '0;
		void'($urandom(13));
		repeat (10) @(posedge clk_in);
		rst_in <= 1'h0;
		wb(1'h0, MAZF_OFS_STATUS, 32'h0);
		check("status reset", rd, MAZF_RST_WORD);
		wb(1'h1, 8'h30, 32'hFFFFFFFF);
		wb(1'h0, 8'h30, 32'h0);
		check("unmapped read", rd, 32'h0);
		k = 0;
		for (int m = 0; m < 4; m++) begin
			for (int w = 0; w < 4; w++) begin
				if (m > 0 && w == 3) continue;
				wb(1'h1, MAZF_OFS_CTRL, 32'h10 | 32'(m) | 32'(w << 2));
				n = (m == 0) ? (w == 0 ? 1 : 1 << (w + 1)) : (1 << (m + 1)) - 1;
				smp.delete();
				repeat (n) smp.push_back(12'($urandom));
				i_mazf_seq_model.slow = k[0];
				send_set(m, w, 3'(k % 7), 1'h1, smp);
				k++;
			end
		end
		wb(1'h1, MAZF_OFS_CTRL, 32'h0);
		i_mazf_seq_model.q.push_back({3'h1, 12'hFFF});
		exp_q.push_back({3'h1, 12'h3FF});
		drain();
		wb(1'h0, MAZF_OFS_RESULT, 32'h0);
		check("result register", rd, 32'h0001_03FF);
		wb(1'h1, MAZF_OFS_CTRL, 32'h14);
		repeat (2) i_mazf_seq_model.q.push_back({3'h2, 12'h0F0});
		send_set(0, 1, 3'h3, 1'h1, smp[0:3]);
		for (int c = 0; c < 3; c++) begin
			wb(1'h1, MAZF_OFS_AUX_LO + 8'(8 * c), 32'(12'h200 * (c + 1)));
			wb(1'h1, MAZF_OFS_AUX_HI + 8'(8 * c), 32'(12'h200 * (c + 1) + 12'h300));
		end
		wb(1'h0, MAZF_OFS_T2_HI, 32'h0);
		check("thermal two high", rd, 32'h0000_0900);
		wb(1'h1, MAZF_OFS_CTRL, 32'h10);
		i_mazf_seq_model.slow = 1'h1;
		// mode 3 is the never-hit zone: every monitored result is dropped, no flag
		for (int md = 0; md < 4; md++) begin
			wb(1'h1, MAZF_OFS_ZONE, 32'h7 | 32'(md << 4) | 32'(md << 6) | 32'(md << 8));
			fl = 3'h0;
			for (int c = 0; c < 3; c++) begin
				lo = 12'(12'h200 * (c + 1));
				hi = lo + 12'h300;
				for (int t = 0; t < 4; t++) begin
					v = (t < 2) ? lo + 12'(t) : hi + 12'(t) - 12'h3;
					hit = (md == 0) ? v >= hi : (md == 1) ? (v > lo && v < hi) :
						(md == 2) && v <= lo;
					fl[c] = fl[c] | hit;
					send_set(0, 0, 3'(4 + c), hit, {v});
				end
			end
			send_set(0, 0, 3'h0, 1'h1, {12'h000});
			wb(1'h0, MAZF_OFS_STATUS, 32'h0);
			check("ready flags", 32'(rd[2:0]), 32'(fl));
			check("alert pin", 32'(alert_n), 32'(fl == 3'h0));
			wb(1'h1, MAZF_OFS_STATUS, 32'h7);
			wb(1'h0, MAZF_OFS_STATUS, 32'h0);
			check("flags cleared", 32'(rd[2:0]), 32'h0);
			check("alert released", 32'(alert_n), 32'h1);
		end
		wb(1'h1, MAZF_OFS_ZONE, 32'h3);
		send_set(0, 0, 3'h6, 1'h1, {12'h000});
		wb(1'h0, MAZF_OFS_STATUS, 32'h0);
		check("disabled channel flag", 32'(rd[2:0]), 32'h0);
		finish_test();
	end
endmodule
`default_nettype wire
